/* File: design/isc_ctrl.sv */
// serial bus controller: register port, line sampling and slave address matching
`timescale 1ns/1ps
`include "isc_regs.svh"
module isc_ctrl import isc_pkg::*; (
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  wire logic         req_valid_in,
    input  wire isc_req_type  req_in,
    output logic              ack_out,
    output logic              deny_out,
    output logic [31:0]       rdata_out,
    input  wire isc_line_type line_in,
    output logic              sda_out,
    output logic              sda_oe_out,
    output logic              scl_out,
    output logic              scl_oe_out
);
    logic [7:0]    own_addr_reg;
    logic [7:0]    div_code_reg;
    logic [7:0]    control_reg;
    logic [7:0]    xfer_reg;
    logic [7:0]    shift_reg;
    logic [3:0]    bit_cnt_reg;
    logic          srw_reg;
    logic          iaas_reg;
    logic          busy_reg;
    logic          rxak_reg;
    logic          tcf_reg;
    logic          rx_done;
    logic          tx_done;
    isc_state_type state_reg;
    isc_line_type  smp_reg;
    isc_line_type  prv_reg;
    logic          tick;
    logic          en;
    logic          in_win;
    logic          hit;
    logic          wr_hit;
    logic          rd_xfer;
    logic          start_det;
    logic          stop_det;
    logic          scl_rise;
    logic          scl_fall;
    logic          addr_match;

    // only aligned words inside the controller window count as ours
    function automatic logic isc_in_window(input logic [11:0] a);
        isc_in_window = (a >= `ISC_OFS_OWN_ADDR) && (a <= `ISC_OFS_XFER) && (a[1:0] == 2'b00);
    endfunction : isc_in_window

    // byte of the register selected by offset, reserved bits already zero
    function automatic logic [7:0] isc_read_byte(input logic [11:0] a, input logic [7:0] st);
        if (a == `ISC_OFS_OWN_ADDR) begin
            isc_read_byte = own_addr_reg;
        end else if (a == `ISC_OFS_DIVIDER) begin
            isc_read_byte = div_code_reg;
        end else if (a == `ISC_OFS_CONTROL) begin
            isc_read_byte = control_reg;
        end else if (a == `ISC_OFS_STATUS) begin
            isc_read_byte = st;
        end else if (a == `ISC_OFS_XFER) begin
            isc_read_byte = xfer_reg;
        end else begin
            isc_read_byte = 8'h00;
        end
    endfunction : isc_read_byte

    isc_prescaler u_prescaler (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .code_in  (div_code_reg[`ISC_CODE_W-1:0]),
        .tick_out (tick)
    );

    // external masters may reach the controller window only; internal ones everywhere
    assign in_win  = isc_in_window(req_in.addr);
    assign hit     = req_valid_in && (in_win || !req_in.ext); // [R02]
    assign wr_hit  = hit && req_in.wr && in_win;
    assign rd_xfer = hit && !req_in.wr && (req_in.addr == `ISC_OFS_XFER);
    assign en      = control_reg[`ISC_CTL_EN];

    // answer one cycle after the request; denied accesses neither read nor write
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_out   <= 1'b0;
            deny_out  <= 1'b0;
            rdata_out <= 32'h0000_0000;
        end else begin
            ack_out   <= hit;
            deny_out  <= req_valid_in && !hit; // [R02]
            rdata_out <= 32'h0000_0000; // lower lanes stay zero [R12]
            if (hit && !req_in.wr) begin
                rdata_out[`ISC_LANE_HI:`ISC_LANE_LO] <= isc_read_byte(req_in.addr,
                    {tcf_reg, iaas_reg, busy_reg, 2'b00, srw_reg, 1'b0, rxak_reg}); // [R01]
            end
        end
    end

    // software-written configuration; reserved bits masked on the way in
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            own_addr_reg <= `ISC_RST_BYTE;
            div_code_reg <= `ISC_RST_BYTE;
            control_reg  <= `ISC_RST_BYTE;
        end else if (wr_hit) begin
            if (req_in.addr == `ISC_OFS_OWN_ADDR) begin
                own_addr_reg <= req_in.wdata[`ISC_LANE_HI:`ISC_LANE_LO] & `ISC_ADR_MASK; // [R04] [R12]
            end else if (req_in.addr == `ISC_OFS_DIVIDER) begin
                div_code_reg <= req_in.wdata[`ISC_LANE_HI:`ISC_LANE_LO] & `ISC_DIV_MASK; // [R06] [R09]
            end else if (req_in.addr == `ISC_OFS_CONTROL) begin
                control_reg  <= req_in.wdata[`ISC_LANE_HI:`ISC_LANE_LO] & `ISC_CTL_MASK; // [R12]
            end
        end
    end

    // transfer byte: software loads it, a received byte overwrites it
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            xfer_reg <= `ISC_RST_BYTE;
        end else if (rx_done) begin
            xfer_reg <= shift_reg;
        end else if (wr_hit && req_in.addr == `ISC_OFS_XFER) begin
            xfer_reg <= req_in.wdata[`ISC_LANE_HI:`ISC_LANE_LO];
        end
    end

    // byte-complete flag: reading the transfer byte clears it, a new byte wins
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tcf_reg <= 1'b0;
        end else if (rx_done || tx_done) begin
            tcf_reg <= 1'b1;
        end else if (rd_xfer) begin
            tcf_reg <= 1'b0;
        end
    end

    // lines are only looked at on prescaler ticks, riding out slow edges [R08]
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            smp_reg <= '{scl: 1'b1, sda: 1'b1};
            prv_reg <= '{scl: 1'b1, sda: 1'b1};
        end else if (tick) begin
            smp_reg <= line_in; // [R08]
            prv_reg <= smp_reg;
        end
    end

    assign start_det  = prv_reg.scl && smp_reg.scl && prv_reg.sda && !smp_reg.sda;
    assign stop_det   = prv_reg.scl && smp_reg.scl && !prv_reg.sda && smp_reg.sda;
    assign scl_rise   = !prv_reg.scl && smp_reg.scl;
    assign scl_fall   = prv_reg.scl && !smp_reg.scl;
    // seven received bits against our own; direction bit excluded [R10]
    assign addr_match = (shift_reg[7:1] == own_addr_reg[7:1]);
    assign rx_done    = tick && en && state_reg == ISC_DATA && scl_fall && bit_cnt_reg == `ISC_BITS_PER_BYTE
                        && !srw_reg;
    assign tx_done    = tick && en && state_reg == ISC_DATA && scl_fall && bit_cnt_reg == `ISC_BITS_PER_BYTE
                        && srw_reg;

    // bus busy between a start and a stop seen on the lines
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_reg <= 1'b0;
        end else if (tick && start_det) begin
            busy_reg <= 1'b1;
        end else if (tick && stop_det) begin
            busy_reg <= 1'b0;
        end
    end

    // slave engine; outgoing addresses are never formed here, own address is matched only [R03]
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg   <= ISC_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            srw_reg     <= 1'b0;
            iaas_reg    <= 1'b0;
            rxak_reg    <= 1'b0;
            sda_oe_out  <= 1'b0;
        end else if (!en) begin
            // disabled: release the line and wait for the next start
            state_reg   <= ISC_IDLE;
            iaas_reg    <= 1'b0;
            sda_oe_out  <= 1'b0;
        end else if (tick) begin
            if (start_det) begin
                state_reg   <= ISC_ADDR; // repeated start lands here too
                bit_cnt_reg <= 4'h0;
                iaas_reg    <= 1'b0;
                sda_oe_out  <= 1'b0;
            end else if (stop_det) begin
                state_reg   <= ISC_IDLE;
                iaas_reg    <= 1'b0;
                sda_oe_out  <= 1'b0;
            end else begin
                case (state_reg)
                    ISC_ADDR: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], smp_reg.sda}; // msb first [R10]
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == `ISC_BITS_PER_BYTE) begin
                            if (addr_match) begin
                                state_reg  <= ISC_ACK; // [R05]
                                srw_reg    <= shift_reg[0];
                                iaas_reg   <= 1'b1;
                                sda_oe_out <= 1'b1; // acknowledge the call
                            end else begin
                                state_reg  <= ISC_IDLE;
                            end
                        end
                    end
                    ISC_ACK: begin
                        if (scl_rise && !sda_oe_out) begin
                            rxak_reg <= smp_reg.sda; // master's answer to our byte
                        end else if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (srw_reg && !sda_oe_out && rxak_reg) begin
                                state_reg  <= ISC_IDLE; // no ack: master wants no more
                                sda_oe_out <= 1'b0;
                            end else if (srw_reg) begin
                                state_reg  <= ISC_DATA;
                                shift_reg  <= xfer_reg;
                                sda_oe_out <= !xfer_reg[7];
                            end else begin
                                state_reg  <= ISC_DATA;
                                sda_oe_out <= 1'b0;
                            end
                        end
                    end
                    ISC_DATA: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (!srw_reg) begin
                                shift_reg <= {shift_reg[6:0], smp_reg.sda};
                            end
                        end else if (scl_fall && bit_cnt_reg == `ISC_BITS_PER_BYTE) begin
                            state_reg  <= ISC_ACK;
                            sda_oe_out <= !srw_reg && !control_reg[`ISC_CTL_TXAK];
                        end else if (scl_fall && srw_reg) begin
                            shift_reg  <= {shift_reg[6:0], 1'b0};
                            sda_oe_out <= !shift_reg[6];
                        end
                    end
                    default: begin
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: the pin only ever pulls low; the clock line is never stretched
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sda_out    <= 1'b0;
            scl_out    <= 1'b0;
            scl_oe_out <= 1'b0;
        end else begin
            sda_out    <= 1'b0;
            scl_out    <= 1'b0;
            scl_oe_out <= 1'b0;
        end
    end

    // a start on a quiet bus takes the engine into address reception
    sequence s_start_seen;
        tick && en && start_det;
    endsequence

    sequence s_addr_taken;
        state_reg == ISC_ADDR && bit_cnt_reg == 4'h0;
    endsequence

    a_start_to_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R10]
        s_start_seen |=> s_addr_taken) else $error("start did not open address phase");
    a_match_acks: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R05]
        (state_reg == ISC_ADDR && $past(state_reg) == ISC_ADDR) ##1 state_reg == ISC_ACK |-> iaas_reg && sda_oe_out)
        else $error("address match without slave acknowledge");
    a_nomatch_idle: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R10]
        tick && en && state_reg == ISC_ADDR && !start_det && !stop_det && scl_fall && bit_cnt_reg == 4'h8
        && !addr_match |=> state_reg == ISC_IDLE) else $error("foreign address was answered");
    a_rsv_lanes: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R01] [R12]
        rdata_out[23:0] == 24'h000000) else $error("reserved byte lanes not zero");
    a_ext_denied: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R02]
        req_valid_in && req_in.ext && !in_win |=> deny_out && !ack_out) else $error("external access not denied");
    a_addr_bit0: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R04]
        wr_hit && req_in.addr == 12'h280 |=> own_addr_reg[0] == 1'b0
        && own_addr_reg[7:1] == $past(req_in.wdata[31:25])) else $error("own address write wrong");
    a_code_live: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R06] [R09]
        wr_hit && req_in.addr == 12'h284 |=> div_code_reg == {2'b00, $past(req_in.wdata[29:24])})
        else $error("clock-rate code not applied");
    a_sample_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R08]
        !tick |=> $stable(smp_reg)) else $error("lines sampled off the prescaler tick");
    a_idle_quiet: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R05]
        state_reg == ISC_IDLE ##1 state_reg == ISC_IDLE |-> !sda_oe_out) else $error("line driven while idle");

    // byte ends, the disabled engine and refused accesses: the cases a user relies on most
    a_rx_lands: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R10]
        rx_done |=> xfer_reg == $past(shift_reg) && tcf_reg) else $error("received byte not stored");
    a_off_quiet: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R05]
        !en |=> !sda_oe_out && !iaas_reg) else $error("disabled engine still active");
    a_denied_nowr: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R02]
        req_valid_in && req_in.ext && !in_win |=> $stable(own_addr_reg) && $stable(div_code_reg)
        && $stable(control_reg)) else $error("denied access changed a register");
    a_tx_release: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R10]
        tx_done |=> state_reg == ISC_ACK && !sda_oe_out) else $error("slave kept the line after its byte");
endmodule : isc_ctrl

/* File: design/isc_regs.svh */
// register offsets, field positions, reset values and widths of the serial bus controller
// Notes on behaviour
// [R01] five byte registers at offsets 0x280..0x290, stride four, in lane 31:24
// [R02] external masters reach every controller register, but nothing else in peripheral space
// [R03] own slave address is matched only, never sent as an outgoing address
// [R04] own slave address sits in bits 7..1; bit 0 reserved, reads zero
// [R05] a matching calling address puts the controller into slave mode
// [R06] six-bit clock-rate code in bits 5..0 selects the system clock divider
// [R07] code-to-divider mapping follows the fixed 64-entry table
// [R08] clock and data lines are sampled at the prescaler rate
// [R09] a new clock-rate code takes effect at once, without reset or disable
// [R10] calling address is seven bits msb first plus one direction bit
// [R11] a master never sends a calling address equal to our own
// [R12] reserved bits and lanes read zero and ignore writes
// [R13] prescaler counts system clocks, reloads from divider, one tick per period
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH
`define ISC_OFS_OWN_ADDR  12'h280
`define ISC_OFS_DIVIDER   12'h284
`define ISC_OFS_CONTROL   12'h288
`define ISC_OFS_STATUS    12'h28c
`define ISC_OFS_XFER      12'h290
`define ISC_LANE_HI       31
`define ISC_LANE_LO       24
`define ISC_ADR_MASK      8'hfe
`define ISC_DIV_MASK      8'h3f
`define ISC_CTL_MASK      8'hf8
`define ISC_CTL_EN        7
`define ISC_CTL_TXAK      3
`define ISC_ST_TCF        7
`define ISC_ST_IAAS       6
`define ISC_ST_BUSY       5
`define ISC_ST_SRW        2
`define ISC_ST_RXAK       0
`define ISC_RST_BYTE      8'h00
`define ISC_BITS_PER_BYTE 4'h8
`define ISC_CODE_W        6
`define ISC_DIV_W         12
`endif

/* File: design/isc_pkg.sv */
// types shared by the serial bus controller
package isc_pkg;
    // gray coded along idle -> address -> ack -> data
    typedef enum logic [1:0] {
        ISC_IDLE = 2'b00,
        ISC_ADDR = 2'b01,
        ISC_ACK  = 2'b11,
        ISC_DATA = 2'b10
    } isc_state_type;

    // one register access as presented on the peripheral port
    typedef struct packed {
        logic        wr;
        logic        ext;
        logic [11:0] addr;
        logic [31:0] wdata;
    } isc_req_type;

    // the two bus lines as seen or sampled
    typedef struct packed {
        logic scl;
        logic sda;
    } isc_line_type;
endpackage : isc_pkg

/* File: design/isc_prescaler.sv */
// clock-rate prescaler: table lookup and reloading counter giving one tick per period
`timescale 1ns/1ps
`include "isc_regs.svh"
module isc_prescaler import isc_pkg::*; (
    input  wire logic                   mclk_in,
    input  wire logic                   rstn_in,
    input  wire logic [`ISC_CODE_W-1:0] code_in,
    output logic                        tick_out
);
    logic [`ISC_DIV_W-1:0] cnt_reg;
    logic [`ISC_DIV_W-1:0] div;

    // divider table, three codes to a line
    function automatic logic [`ISC_DIV_W-1:0] isc_divider(input logic [`ISC_CODE_W-1:0] c);
        case (c)
            6'h00: isc_divider = 12'd28;   6'h01: isc_divider = 12'd30;   6'h02: isc_divider = 12'd34;
            6'h03: isc_divider = 12'd40;   6'h04: isc_divider = 12'd44;   6'h05: isc_divider = 12'd48;
            6'h06: isc_divider = 12'd56;   6'h07: isc_divider = 12'd68;   6'h08: isc_divider = 12'd80;
            6'h09: isc_divider = 12'd88;   6'h0a: isc_divider = 12'd104;  6'h0b: isc_divider = 12'd128;
            6'h0c: isc_divider = 12'd144;  6'h0d: isc_divider = 12'd160;  6'h0e: isc_divider = 12'd192;
            6'h0f: isc_divider = 12'd240;  6'h10: isc_divider = 12'd288;  6'h11: isc_divider = 12'd320;
            6'h12: isc_divider = 12'd384;  6'h13: isc_divider = 12'd480;  6'h14: isc_divider = 12'd576;
            6'h15: isc_divider = 12'd640;  6'h16: isc_divider = 12'd768;  6'h17: isc_divider = 12'd960;
            6'h18: isc_divider = 12'd1152; 6'h19: isc_divider = 12'd1280; 6'h1a: isc_divider = 12'd1536;
            6'h1b: isc_divider = 12'd1920; 6'h1c: isc_divider = 12'd2304; 6'h1d: isc_divider = 12'd2560;
            6'h1e: isc_divider = 12'd3072; 6'h1f: isc_divider = 12'd3840; 6'h20: isc_divider = 12'd20;
            6'h21: isc_divider = 12'd22;   6'h22: isc_divider = 12'd24;   6'h23: isc_divider = 12'd26;
            6'h24: isc_divider = 12'd28;   6'h25: isc_divider = 12'd32;   6'h26: isc_divider = 12'd36;
            6'h27: isc_divider = 12'd40;   6'h28: isc_divider = 12'd48;   6'h29: isc_divider = 12'd56;
            6'h2a: isc_divider = 12'd64;   6'h2b: isc_divider = 12'd72;   6'h2c: isc_divider = 12'd80;
            6'h2d: isc_divider = 12'd96;   6'h2e: isc_divider = 12'd112;  6'h2f: isc_divider = 12'd128;
            6'h30: isc_divider = 12'd160;  6'h31: isc_divider = 12'd192;  6'h32: isc_divider = 12'd224;
            6'h33: isc_divider = 12'd256;  6'h34: isc_divider = 12'd320;  6'h35: isc_divider = 12'd384;
            6'h36: isc_divider = 12'd448;  6'h37: isc_divider = 12'd512;  6'h38: isc_divider = 12'd640;
            6'h39: isc_divider = 12'd768;  6'h3a: isc_divider = 12'd896;  6'h3b: isc_divider = 12'd1024;
            6'h3c: isc_divider = 12'd1280; 6'h3d: isc_divider = 12'd1536; 6'h3e: isc_divider = 12'd1792;
            default: isc_divider = 12'd2048;
        endcase
    endfunction : isc_divider

    assign div = isc_divider(code_in); // [R07]

    // ">=" rather than "==": a smaller divider written mid-count wraps at once [R09]
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg  <= 12'h000;
            tick_out <= 1'b0;
        end else if (cnt_reg >= div - 12'h001) begin
            cnt_reg  <= 12'h000; // [R13]
            tick_out <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 12'h001;
            tick_out <= 1'b0;
        end
    end

    a_tick_spacing: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R13]
        tick_out |=> !tick_out [*8]) else $error("prescaler ticks closer than the smallest divider");
    a_count_bound: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R07]
        (cnt_reg == 12'd3) |=> (cnt_reg == 12'd4) || (code_in != $past(code_in)))
        else $error("prescaler counter stalled or wrapped early");
endmodule : isc_prescaler

/* File: verification/isc_master_model.sv */
// behavioural two-wire bus master that calls the controller as a slave
`timescale 1ns/1ps
module isc_master_model import isc_pkg::*; #(
    parameter int HALF = 60
) (
    input  wire logic   mclk_in,
    input  wire logic   sda_oe_in,
    input  wire logic   scl_oe_in,
    output isc_line_type line_out
);
    logic scl_low;
    logic sda_low;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // open-drain wires with pull-ups: low while any party pulls
    assign line_out.scl = !(scl_low | scl_oe_in);
    assign line_out.sda = !(sda_low | sda_oe_in);
    // each phase spans three ticks at the chosen divider, so every level is seen at least three times
    task automatic phase();
        repeat (HALF) @(posedge mclk_in);
        #1;
    endtask : phase
    // sda only moves while scl is low
    task automatic one_bit(input logic b, output logic r);
        sda_low = !b;
        phase();
        scl_low = 1'b0;
        phase();
        r       = line_out.sda;
        scl_low = 1'b1;
        phase();
    endtask : one_bit
    task automatic start();
        phase();
        sda_low = 1'b1;
        phase();
        scl_low = 1'b1;
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        phase();
        scl_low = 1'b0;
        phase();
        sda_low = 1'b0;
        phase();
    endtask : stop
    // eight bits msb first then the ninth clock with sda released
    // callers send calling addresses and data bytes alike through this task
    task automatic xfer(input logic [7:0] b, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(b[i], r);
        end
        one_bit(1'b1, nack);
    endtask : xfer
    // master receive: eight bits read msb first, then no-acknowledge to end the read
    task automatic recv(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b1, r);
            b[i] = r;
        end
        one_bit(1'b1, r);
    endtask : recv
endmodule : isc_master_model

/* File: verification/test_isc_ctrl.sv */
// self-checking bench: register map, access rules and slave addressing
`timescale 1ns/1ps
`include "isc_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_isc_ctrl import isc_pkg::*; ();
    logic         mclk_in;
    logic         rstn_in;
    logic         req_valid;
    isc_req_type  req;
    logic         ack;
    logic         deny;
    logic [31:0]  rdata;
    isc_line_type line;
    logic         sda_o;
    logic         sda_oe;
    logic         scl_o;
    logic         scl_oe;
    int           checks;
    int           fails;
    logic [31:0]  rd;
    logic         dn;
    logic         nack;
    logic [7:0]   rb;
    logic [11:0]  offs [5] = '{`ISC_OFS_OWN_ADDR, `ISC_OFS_DIVIDER, `ISC_OFS_CONTROL, `ISC_OFS_STATUS, `ISC_OFS_XFER};
    isc_ctrl dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_valid_in(req_valid), .req_in(req), .ack_out(ack),
                    .deny_out(deny), .rdata_out(rdata), .line_in(line), .sda_out(sda_o), .sda_oe_out(sda_oe),
                    .scl_out(scl_o), .scl_oe_out(scl_oe));
    isc_master_model mst_u (.mclk_in(mclk_in), .sda_oe_in(sda_oe), .scl_oe_in(scl_oe), .line_out(line));
    // 200 MHz system clock
    always #2.5 mclk_in = ~mclk_in;
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    // one-cycle request; exactly one of ack or deny answers in the next cycle
    task automatic access(input logic wr, input logic ext, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk_in);
        #1;
        req_valid = 1'b1;
        req       = '{wr, ext, a, wd};
        @(posedge mclk_in);
        #1;
        req_valid = 1'b0;
        rd        = rdata;
        dn        = deny;
        `CHK(ack ^ deny, 1'b1)
    endtask : access
    // lower lanes filled with ones so that ignored lanes are exercised
    task automatic wr8(input logic [11:0] a, input logic [7:0] b);
        access(1'b1, 1'b0, a, {b, 24'hffffff});
    endtask : wr8
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        access(1'b0, 1'b0, a, 32'h0);
        `CHK(rd, {e, 24'h000000})
    endtask : rd_chk
    // cycles from one prescaler tick to the next, bounded above the largest divider
    task automatic gap_chk(input logic [7:0] c, input int e);
        int n;
        wr8(`ISC_OFS_DIVIDER, c);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge mclk_in);
                #1;
                n++;
            end while (dut_u.tick !== 1'b1 && n < 4000);
        end
        `CHK(n, e)
    endtask : gap_chk
    initial begin
        #400000;
        fails++;
        summarize();
    end
    initial begin
        mclk_in = 1'b0; rstn_in = 1'b0; req_valid = 1'b0; req = '0; checks = 0; fails = 0;
        repeat (8) @(posedge mclk_in);
        #1;
        rstn_in = 1'b1;
        foreach (offs[i]) rd_chk(offs[i], 8'h00);
        wr8(`ISC_OFS_OWN_ADDR, 8'hff);
        rd_chk(`ISC_OFS_OWN_ADDR, 8'hfe);
        wr8(`ISC_OFS_CONTROL, 8'hff);
        rd_chk(`ISC_OFS_CONTROL, 8'hf8);
        wr8(`ISC_OFS_CONTROL, 8'h00);
        wr8(`ISC_OFS_STATUS, 8'hff);
        rd_chk(`ISC_OFS_STATUS, 8'h00);
        rd_chk(12'h294, 8'h00);
        rd_chk(12'h281, 8'h00);
        // external masters reach the controller window only
        access(1'b1, 1'b1, `ISC_OFS_OWN_ADDR, 32'h54000000);
        `CHK(dn, 1'b0)
        access(1'b0, 1'b1, `ISC_OFS_OWN_ADDR, 32'h0);
        `CHK(rd, 32'h54000000)
        access(1'b0, 1'b1, 12'h000, 32'h0);
        `CHK({dn, rd}, {1'b1, 32'h0})
        access(1'b1, 1'b1, 12'h294, 32'hff000000);
        `CHK(dn, 1'b1)
        for (int c = 0; c < 64; c++) begin
            wr8(`ISC_OFS_DIVIDER, 8'(c) | 8'hc0);
            rd_chk(`ISC_OFS_DIVIDER, 8'(c));
        end
        gap_chk(8'h07, 68);
        gap_chk(8'h2e, 112);
        gap_chk(8'h1f, 3840);
        // disabled engine never answers even its own address
        mst_u.start();
        mst_u.xfer(8'h54, nack);
        `CHK(nack, 1'b1)
        mst_u.stop();
        wr8(`ISC_OFS_CONTROL, 8'h80);
        wr8(`ISC_OFS_DIVIDER, 8'h20);
        mst_u.start();
        mst_u.xfer(8'h54, nack);
        `CHK(nack, 1'b0)
        mst_u.xfer(8'h5a, nack);
        `CHK(nack, 1'b0)
        mst_u.stop();
        access(1'b0, 1'b0, `ISC_OFS_STATUS, 32'h0);
        `CHK(rd[31], 1'b1)
        rd_chk(`ISC_OFS_XFER, 8'h5a);
        access(1'b0, 1'b0, `ISC_OFS_STATUS, 32'h0);
        `CHK(rd[31], 1'b0)
        // another slave's address draws no acknowledge
        mst_u.start();
        mst_u.xfer(8'h56, nack);
        `CHK(nack, 1'b1)
        mst_u.stop();
        // no-acknowledge selected for received data bytes
        wr8(`ISC_OFS_CONTROL, 8'h88);
        mst_u.start();
        mst_u.xfer(8'h54, nack);
        `CHK(nack, 1'b0)
        mst_u.xfer(8'h33, nack);
        `CHK(nack, 1'b1)
        mst_u.stop();
        // master reads the transfer byte back through the slave transmitter
        wr8(`ISC_OFS_XFER, 8'ha5);
        mst_u.start();
        mst_u.xfer(8'h55, nack);
        `CHK(nack, 1'b0)
        mst_u.recv(rb);
        `CHK(rb, 8'ha5)
        access(1'b0, 1'b0, `ISC_OFS_STATUS, 32'h0);
        `CHK(rd[31:24], 8'he5)
        mst_u.stop();
        `CHK({sda_o, scl_o, scl_oe}, 3'b000)
        summarize();
    end
endmodule : test_isc_ctrl
